/* dcec_pkg.sv */
// package for the dma channel enable control block
// assumes a single core_clk domain and an apb register bus
package dcec_pkg;

  // ******************************************
  // register map
  // ******************************************
  localparam logic [7:0]  ENABLE_REG_OFS   = 8'h00;
  localparam logic [7:0]  MODE_REG_OFS     = 8'h04;
  localparam logic [7:0]  STATUS_REG_OFS   = 8'h08;
  localparam logic [7:0]  COUNT_REG_OFS    = 8'h0C;
  localparam logic [7:0]  FIFO_REG_OFS     = 8'h10;
  localparam logic [7:0]  FIFOSTAT_REG_OFS = 8'h14;

  // ******************************************
  // field layout and reset values
  // ******************************************
  localparam int          CHANNELS         = 6;
  localparam int          AUTOINIT_POS     = 8;
  localparam int          COUNT_WIDTH      = 16;
  localparam logic [5:0]  ENABLE_RESET     = 6'h00;
  localparam logic [15:0] COUNT_RESET      = 16'h0004;
  localparam int          FIFO_DEPTH       = 32;
  localparam int          FIFO_WIDTH       = 32;

  typedef enum logic [1:0]
  {
    CH_IDLE = 2'b00,
    CH_MOVE = 2'b01,
    CH_DONE = 2'b10
  } dcec_chstate_t;

endpackage

/* dcec_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
// assumes one clock and an active low asynchronous reset
module dcec_fifo
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    wrPtr_d;
  logic [AW-1:0]    rdPtr_q;
  logic [AW-1:0]    rdPtr_d;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  always_comb
  begin
    inReady  = (count_q != (AW+1)'(DEPTH));
    outValid = (count_q != '0);
    push     = inValid && inReady;
    pop      = outValid && outReady;
    wrPtr_d  = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d  = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
    count_d  = count_q;
    if (push && !pop)
    begin
      count_d = count_q + 1'b1;
    end
    else if (pop && !push)
    begin
      count_d = count_q - 1'b1;
    end
    outData = mem_q[rdPtr_q];
    level   = count_q;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // storage has no reset; only written on push
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_q[wrPtr_q] <= inData;
    end
  end

endmodule

/* dcec_enable_ctrl.sv */
// six-channel dma enable control with apb registers and a data fifo
// assumes apb master on core_clk; element requests come from same-clock logic
//
// Contract
// - one enable bit per channel, six channels
// - completion clears bit unless auto mode
// - auto modes keep bit set after completion
// - writing one starts that channel's transfer if its enable bit is clear
//
// The register offsets and the APB slave port were chosen for this implementation.
module dcec_enable_ctrl
#(
  parameter int CHANNELS   = dcec_pkg::CHANNELS,
  parameter int FIFO_DEPTH = dcec_pkg::FIFO_DEPTH
)
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [CHANNELS-1:0] elemReq,
  input  wire logic [31:0]         elemData,
  output logic      [CHANNELS-1:0] channelEnable,
  output logic      [CHANNELS-1:0] blockDone,
  output logic      [CHANNELS-1:0] chanStart
);

  localparam int CW = dcec_pkg::COUNT_WIDTH;
  localparam int FW = $clog2(FIFO_DEPTH);

  // ******************************************
  // state
  // ******************************************
  logic [CHANNELS-1:0] enable_q;
  logic [CHANNELS-1:0] enable_d;
  logic [CHANNELS-1:0] autobuffer_mode_q;
  logic [CHANNELS-1:0] autobuffer_mode_d;
  logic [CHANNELS-1:0] autoinit_mode_q;
  logic [CHANNELS-1:0] autoinit_mode_d;
  logic [CW-1:0]       blockLen_q;
  logic [CW-1:0]       blockLen_d;
  logic [CW-1:0]       remain_q [CHANNELS];
  logic [CW-1:0]       remain_d [CHANNELS];
  logic [CHANNELS-1:0] done_q;
  logic [CHANNELS-1:0] done_d;
  logic [CHANNELS-1:0] start_q;
  logic [CHANNELS-1:0] start_d;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;
  logic [CHANNELS-1:0] moveNow;
  logic [CHANNELS-1:0] completeNow;
  logic [CHANNELS-1:0] wrSet;
  logic                apbAccess;
  logic                enableWr;
  logic                modeWr;
  logic                countWr;
  logic                fifoRd;
  logic                mapped;
  logic                fifoInValid;
  logic                fifoInReady;
  logic                fifoOutValid;
  logic [31:0]         fifoOutData;
  logic [FW:0]         fifoLevel;
  logic [2:0]          grantIdx;
  logic                grantAny;

  // ******************************************
  // apb decode
  // ******************************************
  always_comb
  begin
    apbAccess = psel && penable;
    enableWr  = apbAccess && pwrite && (paddr == dcec_pkg::ENABLE_REG_OFS);
    modeWr    = apbAccess && pwrite && (paddr == dcec_pkg::MODE_REG_OFS);
    countWr   = apbAccess && pwrite && (paddr == dcec_pkg::COUNT_REG_OFS);
    fifoRd    = apbAccess && !pwrite && (paddr == dcec_pkg::FIFO_REG_OFS);
    mapped    = (paddr == dcec_pkg::ENABLE_REG_OFS) || (paddr == dcec_pkg::MODE_REG_OFS)
             || (paddr == dcec_pkg::STATUS_REG_OFS) || (paddr == dcec_pkg::COUNT_REG_OFS)
             || (paddr == dcec_pkg::FIFO_REG_OFS) || (paddr == dcec_pkg::FIFOSTAT_REG_OFS);
    pready    = 1'b1;
    pslverr   = apbAccess && !mapped;
  end

  // ******************************************
  // element arbitration into the fifo
  // ******************************************
  always_comb
  begin
    grantAny = 1'b0;
    grantIdx = 3'h0;
    for (int i = CHANNELS - 1; i >= 0; i--)
    begin
      if (elemReq[i] && enable_q[i])
      begin
        grantAny = 1'b1;
        grantIdx = 3'(i);
      end
    end
    fifoInValid = grantAny;
    moveNow     = '0;
    if (grantAny && fifoInReady)
    begin
      moveNow[grantIdx] = 1'b1;
    end
  end

  // ******************************************
  // per-channel enable, counts and completion
  // ******************************************
  generate
    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_chan
      always_comb
      begin
        completeNow[c] = moveNow[c] && (remain_q[c] == CW'(1));
        wrSet[c]       = enableWr && pwdata[c];
        remain_d[c]    = remain_q[c];
        if (wrSet[c] && !enable_q[c])
        begin
          remain_d[c] = blockLen_q;
        end
        else if (completeNow[c])
        begin
          remain_d[c] = blockLen_q;
        end
        else if (moveNow[c])
        begin
          remain_d[c] = CW'(remain_q[c] - 1'b1);
        end
        // cpu write first, completion overrides it unless the channel is in autobuffer or autoinit mode
        enable_d[c] = enableWr ? pwdata[c] : enable_q[c];
        if (completeNow[c] && !autobuffer_mode_q[c] && !autoinit_mode_q[c])
        begin
          enable_d[c] = 1'b0;
        end
        done_d[c]  = completeNow[c];
        start_d[c] = enable_d[c] && !enable_q[c];
      end

      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          remain_q[c] <= dcec_pkg::COUNT_RESET;
        end
        else
        begin
          remain_q[c] <= remain_d[c];
        end
      end
    end
  endgenerate

  // ******************************************
  // control registers
  // ******************************************
  always_comb
  begin
    autobuffer_mode_d = modeWr ? pwdata[CHANNELS-1:0] : autobuffer_mode_q;
    autoinit_mode_d   = modeWr ? pwdata[dcec_pkg::AUTOINIT_POS +: CHANNELS] : autoinit_mode_q;
    blockLen_d        = blockLen_q;
    if (countWr)
    begin
      blockLen_d = (pwdata[CW-1:0] == '0) ? CW'(1) : pwdata[CW-1:0];
    end
  end

  // ******************************************
  // read data
  // ******************************************
  always_comb
  begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite)
    begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        dcec_pkg::ENABLE_REG_OFS:
          prdata_d[CHANNELS-1:0] = enable_q;
        dcec_pkg::MODE_REG_OFS:
        begin
          prdata_d[CHANNELS-1:0]                          = autobuffer_mode_q;
          prdata_d[dcec_pkg::AUTOINIT_POS +: CHANNELS]    = autoinit_mode_q;
        end
        dcec_pkg::STATUS_REG_OFS:
        begin
          prdata_d[CW-1:0]  = remain_q[paddr[1:0]];
          prdata_d[CW +: 3] = 3'h0;
        end
        dcec_pkg::COUNT_REG_OFS:
          prdata_d[CW-1:0] = blockLen_q;
        dcec_pkg::FIFO_REG_OFS:
          prdata_d = fifoOutValid ? fifoOutData : 32'h0000_0000;
        dcec_pkg::FIFOSTAT_REG_OFS:
          prdata_d[FW:0] = fifoLevel;
        default:
          prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enable_q          <= dcec_pkg::ENABLE_RESET;
      autobuffer_mode_q <= '0;
      autoinit_mode_q   <= '0;
      blockLen_q        <= dcec_pkg::COUNT_RESET;
      done_q            <= '0;
      start_q           <= '0;
      prdata_q          <= 32'h0000_0000;
    end
    else
    begin
      enable_q          <= enable_d;
      autobuffer_mode_q <= autobuffer_mode_d;
      autoinit_mode_q   <= autoinit_mode_d;
      blockLen_q        <= blockLen_d;
      done_q            <= done_d;
      start_q           <= start_d;
      prdata_q          <= prdata_d;
    end
  end

  always_comb
  begin
    prdata        = prdata_q;
    channelEnable = enable_q;
    blockDone     = done_q;
    chanStart     = start_q;
  end

  // ******************************************
  // data fifo
  // ******************************************
  dcec_fifo
  #(
    .WIDTH (dcec_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (elemData),
    .outValid (fifoOutValid),
    .outReady (fifoRd),
    .outData  (fifoOutData),
    .level    (fifoLevel)
  );

endmodule

/* dcec_enable_ctrl_monitor.sv */
// concurrent checks on the ports of the dma channel enable control block
// assumes apb zero wait states and mode written only through apb
module dcec_enable_ctrl_monitor
#(
  parameter int CHANNELS = dcec_pkg::CHANNELS
)
(
  input wire logic                core_clk,
  input wire logic                rst_b,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [CHANNELS-1:0] channelEnable,
  input wire logic [CHANNELS-1:0] blockDone,
  input wire logic [CHANNELS-1:0] chanStart
);
  logic [13:0]         modeQ;
  logic [13:0]         modeD;
  logic [CHANNELS-1:0] autoMask;
  logic                enWr;

  assign enWr     = psel && penable && pwrite && paddr == dcec_pkg::ENABLE_REG_OFS;
  assign autoMask = modeQ[CHANNELS-1:0] | modeQ[dcec_pkg::AUTOINIT_POS +: CHANNELS];

  // shadow of the mode register, to know which channels keep running
  always_comb
  begin
    modeD = modeQ;
    if (psel && penable && pwrite && paddr == dcec_pkg::MODE_REG_OFS)
    begin
      modeD = pwdata[13:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      modeQ <= 14'h0000;
    end
    else
    begin
      modeQ <= modeD;
    end
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence collide_s;
    enWr ##1 ((blockDone & ~autoMask) != 0);
  endsequence

  done_clears_a: assert property ((blockDone & ~autoMask & channelEnable) == 0)
    else $error("enable bit still set at block end");
  auto_keeps_a: assert property ((blockDone & autoMask) != 0 && !$past(enWr)
    |-> (channelEnable & blockDone & autoMask) == (blockDone & autoMask)) else $error("auto channel dropped");
  start_rise_a: assert property (chanStart == (channelEnable & ~$past(channelEnable)))
    else $error("start pulse not tied to enable rise");
  enable_write_a: assert property (enWr |=> ((channelEnable ^ $past(pwdata[CHANNELS-1:0])) & ~blockDone) == 0)
    else $error("enable write not applied");
  enable_hold_a: assert property (!$past(enWr) && blockDone == 0 |-> channelEnable == $past(channelEnable))
    else $error("enable bits moved on their own");
  collide_clear_a: assert property (collide_s |-> ((channelEnable & blockDone & ~autoMask) == 0)
    ##1 ((chanStart & $past(blockDone & ~autoMask)) == 0)) else $error("collision restarted channel");
  unmapped_err_a: assert property (psel && penable && paddr > dcec_pkg::FIFOSTAT_REG_OFS |-> pslverr)
    else $error("no error on unmapped address");
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("access phase not ready");
endmodule

bind dcec_enable_ctrl dcec_enable_ctrl_monitor #(.CHANNELS(CHANNELS)) i_mon (.core_clk(core_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .channelEnable(channelEnable), .blockDone(blockDone), .chanStart(chanStart));

/* dcec_cpu_model.sv */
// apb master standing in for core software
// assumes core_clk from the bench and a slave with pready
module dcec_cpu_model
(
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // called just after a rising edge; more keeps psel for a back-to-back setup
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic more,
                      output logic [31:0] rd);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    penable <= 1'b0;
    if (!more)
    begin
      psel   <= 1'b0;
      pwdata <= ~d;
      @(posedge core_clk);
    end
  endtask

  // sets only the new bits, the rest keep their read-back value
  task automatic or_enable(input logic [5:0] bits);
    logic [31:0] rd;
    xfer(1'b0, dcec_pkg::ENABLE_REG_OFS, 32'h0000_0000, 1'b1, rd);
    xfer(1'b1, dcec_pkg::ENABLE_REG_OFS, rd | {26'h0, bits}, 1'b0, rd);
  endtask
endmodule

/* tb.sv */
// self-checking bench for the dma channel enable control block
// assumes the package, fifo, design, monitor and cpu model compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] prdata, pwdata, elemData, rd;
  logic [7:0]  paddr;
  logic [5:0]  elemReq, reqMask, channelEnable, blockDone, chanStart, doneSeen;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, phase;
  int          failures, checksDone, cyc, startCnt0, doneCnt0;

  // channels 1 and 2 take turns so both finish blocks
  assign elemReq  = reqMask & {3'h7, phase, ~phase, 1'b1};
  assign elemData = 32'(cyc);

  dcec_enable_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .elemReq(elemReq),
    .elemData(elemData), .channelEnable(channelEnable), .blockDone(blockDone), .chanStart(chanStart));
  dcec_cpu_model i_cpu (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc       <= cyc + 1;
    phase     <= ~phase;
    startCnt0 <= startCnt0 + int'(chanStart[0]);
    doneCnt0  <= doneCnt0 + int'(blockDone[0]);
    doneSeen  <= doneSeen | blockDone;
    if (cyc == 4000)
    begin
      failures = failures + 1;
      close_out;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone = checksDone + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    if (failures == 0 && checksDone > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task t_reset;
    chk(32'(channelEnable), 32'h0);
    i_cpu.xfer(1'b0, dcec_pkg::COUNT_REG_OFS, 32'h0, 1'b0, rd);
    chk(rd, {16'h0, dcec_pkg::COUNT_RESET});
  endtask

  // software sets channel 1 on the very edge channel 0 finishes
  task t_collide;
    int s0;
    int d0;
    s0 = startCnt0;
    d0 = doneCnt0;
    reqMask <= 6'h01;
    i_cpu.xfer(1'b1, dcec_pkg::ENABLE_REG_OFS, 32'h1, 1'b1, rd);
    i_cpu.or_enable(6'h02);
    repeat (3) @(posedge core_clk);
    chk(32'(channelEnable), 32'h2);
    chk(32'(doneCnt0 - d0), 32'h1);
    chk(32'(startCnt0 - s0), 32'h1);
    reqMask <= 6'h00;
    i_cpu.xfer(1'b1, dcec_pkg::ENABLE_REG_OFS, 32'h0, 1'b0, rd);
  endtask

  // ch1 autobuffer, ch2 autoinit fill the fifo, then it is drained
  task t_fill_drain;
    int n;
    i_cpu.xfer(1'b1, dcec_pkg::MODE_REG_OFS, 32'h0000_0402, 1'b0, rd);
    i_cpu.xfer(1'b0, dcec_pkg::STATUS_REG_OFS, 32'h0, 1'b0, rd);
    chk(rd, {16'h0, dcec_pkg::COUNT_RESET});
    reqMask <= 6'h06;
    i_cpu.or_enable(6'h06);
    n = 0;
    do
    begin
      i_cpu.xfer(1'b0, dcec_pkg::FIFOSTAT_REG_OFS, 32'h0, 1'b0, rd);
      n = n + 1;
    end
    while (rd !== 32'd32 && n < 100);
    chk(rd, 32'd32);
    chk(32'(channelEnable), 32'h6);
    chk(32'(doneSeen[2:1]), 32'h3);
    reqMask <= 6'h00;
    repeat (32) i_cpu.xfer(1'b0, dcec_pkg::FIFO_REG_OFS, 32'h0, 1'b0, rd);
    i_cpu.xfer(1'b0, dcec_pkg::FIFOSTAT_REG_OFS, 32'h0, 1'b0, rd);
    chk(rd, 32'h0);
    i_cpu.xfer(1'b0, dcec_pkg::FIFO_REG_OFS, 32'h0, 1'b0, rd);
    chk(rd, 32'h0);
    i_cpu.xfer(1'b0, 8'h40, 32'h0, 1'b0, rd);
    chk(rd, 32'h0);
  endtask

  initial
  begin
    rst_b      = 1'b0;
    reqMask    = 6'h00;
    phase      = 1'b0;
    doneSeen   = 6'h00;
    cyc        = 0;
    failures   = 0;
    checksDone = 0;
    startCnt0  = 0;
    doneCnt0   = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_collide;
    t_fill_drain;
    close_out;
  end
endmodule
